/* File: core/epc_panel_ctrl.sv */
// module: front-panel controller for the built-in effects processor
//
// Notes on behaviour
// - 32 programs in two banks of sixteen, exactly one selected.
// - one indicator per bank, the active bank's indicator lit.
// - each full selector revolution toggles the active bank.
// - selector steps both directions; wrap either way toggles bank.
// - landing on a program starts a load lasting about one second.
// - two tempo presses set delay time from their interval.
// - tempo indicator flashes continuously at the set tempo period.
// - store held three seconds writes edits to the selected location.
// - store indicator flashes fast during store, steady one second after.
// - three knobs drive parameters one, two and three of the program.
// - knob indicator lit only while knob equals stored parameter value.
// - while muted the active bank indicator flashes.
// - clip indicator lights when input or processed audio overloads.
// - each footswitch actuation toggles mute unless the mute button is pressed or REG_CTRL is written in the same cycle; operator gives momentary closure.
// - mute silences main output only; listen and aux feeds stay live.
// - at power-up the selected program of the first bank is recalled.
`timescale 1ns/1ps
module epc_panel_ctrl
  import epc_pkg::*;
#(
  parameter int unsigned LOAD_CYC       = LOAD_MS * CYC_PER_MS,
  parameter int unsigned STORE_HOLD_CYC = STORE_HOLD_MS * CYC_PER_MS,
  parameter int unsigned STORE_SHOW_CYC = STORE_SHOW_MS * CYC_PER_MS,
  parameter int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * CYC_PER_MS,
  parameter int unsigned FAST_HALF_CYC  = FAST_FLASH_MS * CYC_PER_MS,
  parameter int unsigned BLINK_HALF_CYC = MUTE_BLINK_MS * CYC_PER_MS,
  parameter int unsigned TEMPO_DEF_CYC  = TEMPO_DEF_MS * CYC_PER_MS,
  parameter int unsigned TEMPO_MAX_CYC  = TEMPO_MAX_MS * CYC_PER_MS
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        irq,
  // front panel
  input  wire logic                   selStep,
  input  wire logic                   selDirDown,
  input  wire logic [NUM_BUTTONS-1:0] buttonRaw,
  input  wire epc_knobs_t             knobValue,
  output epc_leds_t                   leds,
  // effect engine
  input  wire epc_knobs_t             storedValue,
  input  wire logic                   inputClip,
  input  wire logic                   processedClip,
  output epc_knobs_t                  paramValue,
  output epc_engine_t                 engine
);

  // =========================================================
  // reset release
  logic [1:0] rstSync_r;
  logic       rstLocal_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstLocal_n = rstSync_r[1];

  // =========================================================
  // state
  typedef struct packed {
    logic [NUM_BUTTONS-1:0]       btnLevel;
    logic [NUM_BUTTONS-1:0][31:0] btnCnt;
    logic [NUM_BUTTONS-1:0]       btnRaw;
    logic                         bank;
    logic [POS_W-1:0]             pos;
    logic                         loadPend;
    logic [31:0]                  loadCnt;
    logic                         loading;
    logic                         tapArmed;
    logic [31:0]                  tapCnt;
    logic [31:0]                  tempo;
    logic [31:0]                  tempoFlashCnt;
    epc_store_t                   store;
    logic [31:0]                  storeCnt;
    logic [31:0]                  fastCnt;
    logic                         fastPhase;
    logic [31:0]                  blinkCnt;
    logic                         blinkPhase;
    logic                         muted;
    logic [IRQ_W-1:0]             irqStat;
    logic [IRQ_W-1:0]             irqMask;
    logic                         awGot;
    logic [ADDR_W-1:0]            awAddr;
    logic                         wGot;
    logic [31:0]                  wData;
    logic [3:0]                   wStrb;
    logic                         awReady;
    logic                         wReady;
    logic                         bValid;
    logic [1:0]                   bResp;
    logic                         arReady;
    logic                         rValid;
    logic [31:0]                  rData;
    logic [1:0]                   rResp;
    logic                         irqOut;
    epc_leds_t                    leds;
    epc_knobs_t                   param;
    epc_engine_t                  eng;
  } epc_state_t;

  epc_state_t st_r;
  epc_state_t st_nxt;

  // =========================================================
  // helpers
  function automatic logic regKnown(input logic [ADDR_W-1:0] a);
    return a == REG_CTRL || a == REG_STATUS || a == REG_TEMPO ||
           a == REG_IRQ_STAT || a == REG_IRQ_MASK;
  endfunction

  function automatic logic [31:0] countTo(input logic [31:0] c, input int unsigned lim, output logic hit);
    hit = (c >= lim - 1);
    return hit ? 32'h0000_0000 : c + 32'h0000_0001;
  endfunction

  // =========================================================
  // debounced button edges
  logic [NUM_BUTTONS-1:0] btnPress;
  logic [NUM_BUTTONS-1:0] btnNewLevel;
  logic [NUM_BUTTONS-1:0][31:0] btnNewCnt;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BUTTONS; gi++) begin : g_deb
      always_comb begin
        btnNewLevel[gi] = st_r.btnLevel[gi];
        btnNewCnt[gi]   = 32'h0000_0000;
        if (st_r.btnRaw[gi] != st_r.btnLevel[gi]) begin
          if (st_r.btnCnt[gi] >= DEBOUNCE_CYC - 1) begin
            btnNewLevel[gi] = st_r.btnRaw[gi];
          end else begin
            btnNewCnt[gi] = st_r.btnCnt[gi] + 32'h0000_0001;
          end
        end
        btnPress[gi] = btnNewLevel[gi] && !st_r.btnLevel[gi];
      end
    end
  endgenerate

  // =========================================================
  // next state
  always_comb begin
    logic hit;
    logic [POS_W-1:0] nPos;
    logic [IRQ_W-1:0] evt;
    logic             rdStat;
    logic             bankLit;
    hit    = 1'b0;
    nPos   = st_r.pos;
    evt    = '0;
    rdStat = 1'b0;
    st_nxt = st_r;

    st_nxt.btnRaw   = buttonRaw;
    st_nxt.btnLevel = btnNewLevel;
    st_nxt.btnCnt   = btnNewCnt;
    st_nxt.eng.loadStart  = 1'b0;
    st_nxt.eng.storeWrite = 1'b0;
    st_nxt.eng.tempoSet   = 1'b0;

    // selector: sixteen detents per turn, wrap toggles bank
    if (selStep) begin
      if (selDirDown) begin
        nPos = st_r.pos - 4'h1;
        if (st_r.pos == POS_FIRST) st_nxt.bank = ~st_r.bank;
      end else begin
        nPos = st_r.pos + 4'h1;
        if (st_r.pos == POS_LAST) st_nxt.bank = ~st_r.bank;
      end
      st_nxt.pos      = nPos;
      st_nxt.loadPend = 1'b1;
    end

    // load start, held off while a store is being written or shown
    if (st_r.loadPend && st_r.store != ST_WRITE && st_r.store != ST_SHOW && !selStep) begin
      st_nxt.loadPend      = 1'b0;
      st_nxt.loading       = 1'b1;
      st_nxt.loadCnt       = 32'h0000_0000;
      st_nxt.eng.loadStart = 1'b1;
      st_nxt.eng.loadProg  = {st_r.bank, st_r.pos};
    end else if (st_r.loading) begin
      st_nxt.loadCnt = countTo(st_r.loadCnt, LOAD_CYC, hit);
      if (hit) begin
        st_nxt.loading = 1'b0;
        evt[IRQ_LOAD]  = 1'b1;
      end
    end

    // tap tempo
    if (st_r.tapArmed) begin
      st_nxt.tapCnt = st_r.tapCnt + 32'h0000_0001;
      if (st_r.tapCnt >= TEMPO_MAX_CYC - 1) st_nxt.tapArmed = 1'b0;
    end
    if (btnPress[BTN_TEMPO]) begin
      if (st_r.tapArmed && st_r.tapCnt < TEMPO_MAX_CYC - 1) begin
        st_nxt.tempo           = st_r.tapCnt + 32'h0000_0001;
        st_nxt.eng.tempoSet    = 1'b1;
        st_nxt.eng.tempoCycles = st_r.tapCnt + 32'h0000_0001;
        st_nxt.tapArmed        = 1'b0;
        st_nxt.tempoFlashCnt   = 32'h0000_0000;
        evt[IRQ_TEMPO]         = 1'b1;
      end else begin
        st_nxt.tapArmed = 1'b1;
        st_nxt.tapCnt   = 32'h0000_0000;
      end
    end else if (st_r.tempoFlashCnt >= {1'b0, st_r.tempo[31:1]} - 32'h0000_0001) begin
      st_nxt.tempoFlashCnt = 32'h0000_0000;
      st_nxt.leds.tempoLed = ~st_r.leds.tempoLed;
    end else begin
      st_nxt.tempoFlashCnt = st_r.tempoFlashCnt + 32'h0000_0001;
    end

    // flash timers
    st_nxt.fastCnt = countTo(st_r.fastCnt, FAST_HALF_CYC, hit);
    if (hit) st_nxt.fastPhase = ~st_r.fastPhase;
    st_nxt.blinkCnt = countTo(st_r.blinkCnt, BLINK_HALF_CYC, hit);
    if (hit) st_nxt.blinkPhase = ~st_r.blinkPhase;

    // store sequence
    case (st_r.store)
      ST_IDLE: begin
        st_nxt.storeCnt = 32'h0000_0000;
        if (btnPress[BTN_STORE]) st_nxt.store = ST_HOLD;
      end
      ST_HOLD: begin
        if (!st_r.btnLevel[BTN_STORE]) begin
          st_nxt.store = ST_IDLE;
        end else begin
          st_nxt.storeCnt = countTo(st_r.storeCnt, STORE_HOLD_CYC, hit);
          if (hit) st_nxt.store = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (!st_r.loading && !st_r.eng.loadStart) begin
          st_nxt.eng.storeWrite = 1'b1;
          st_nxt.eng.storeProg  = {st_r.bank, st_r.pos};
          st_nxt.store          = ST_SHOW;
          st_nxt.storeCnt       = 32'h0000_0000;
        end
      end
      ST_SHOW: begin
        st_nxt.storeCnt = countTo(st_r.storeCnt, STORE_SHOW_CYC, hit);
        if (hit) begin
          st_nxt.store    = ST_IDLE;
          evt[IRQ_STORE]  = 1'b1;
        end
      end
      default: st_nxt.store = ST_IDLE;
    endcase
    st_nxt.leds.storeLed = (st_nxt.store == ST_SHOW) ||
                           ((st_nxt.store == ST_HOLD || st_nxt.store == ST_WRITE) && st_nxt.fastPhase);

    // mute from button, footswitch or software
    if (btnPress[BTN_MUTE] ^ btnPress[BTN_FOOT]) st_nxt.muted = ~st_r.muted;
    st_nxt.eng.mainOutMute          = st_nxt.muted;
    st_nxt.eng.preFadeListenFeedOn  = 1'b1;
    st_nxt.eng.processorToAuxSendOn = 1'b1;

    // indicators
    bankLit = !st_nxt.muted || st_nxt.blinkPhase;
    st_nxt.leds.bankALed = !st_nxt.bank && bankLit;
    st_nxt.leds.bankBLed = st_nxt.bank && bankLit;
    st_nxt.leds.clipLed  = inputClip || processedClip;
    if (inputClip || processedClip) evt[IRQ_CLIP] = 1'b1;
    st_nxt.param = knobValue;
    st_nxt.leds.knobLed = {knobValue.k2 == storedValue.k2,
                           knobValue.k1 == storedValue.k1,
                           knobValue.k0 == storedValue.k0};

    // axi4-lite write: address and data in either order
    st_nxt.awReady = 1'b0;
    st_nxt.wReady  = 1'b0;
    if (s_axi_awvalid && st_r.awReady) begin
      st_nxt.awGot  = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wReady) begin
      st_nxt.wGot  = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (st_r.bValid && s_axi_bready) st_nxt.bValid = 1'b0;
    if (st_r.awGot && st_r.wGot && !st_r.bValid) begin
      st_nxt.awGot  = 1'b0;
      st_nxt.wGot   = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = regKnown(st_r.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (st_r.wStrb[0]) begin
        if (st_r.awAddr == REG_CTRL) st_nxt.muted = st_r.wData[CTRL_MUTE];
        if (st_r.awAddr == REG_IRQ_MASK) st_nxt.irqMask = st_r.wData[IRQ_W-1:0];
      end
    end else begin
      st_nxt.awReady = !st_nxt.awGot && !st_r.awReady && !st_r.bValid;
      st_nxt.wReady  = !st_nxt.wGot && !st_r.wReady && !st_r.bValid;
    end

    // axi4-lite read
    st_nxt.arReady = !st_r.rValid && !st_r.arReady && !s_axi_arvalid ? 1'b1 : 1'b0;
    if (!st_r.rValid && !st_r.arReady) st_nxt.arReady = 1'b1;
    if (st_r.rValid && s_axi_rready) st_nxt.rValid = 1'b0;
    if (s_axi_arvalid && st_r.arReady) begin
      st_nxt.arReady = 1'b0;
      st_nxt.rValid  = 1'b1;
      st_nxt.rResp   = regKnown(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_CTRL:     st_nxt.rData = {31'h0000_0000, st_r.muted};
        REG_STATUS:   st_nxt.rData = {23'h00_0000, st_r.store == ST_IDLE ? 1'b0 : 1'b1, st_r.loading,
                                      st_r.muted, st_r.bank, st_r.bank, st_r.pos};
        REG_TEMPO:    st_nxt.rData = st_r.tempo;
        REG_IRQ_STAT: begin
          st_nxt.rData = {28'h000_0000, st_r.irqStat};
          rdStat       = 1'b1;
        end
        REG_IRQ_MASK: st_nxt.rData = {28'h000_0000, st_r.irqMask};
        default:      st_nxt.rData = 32'h0000_0000;
      endcase
    end

    // sticky events: a new event wins over the read-clear
    st_nxt.irqStat = (rdStat ? '0 : st_r.irqStat) | evt;
    st_nxt.irqOut  = |(st_nxt.irqStat & st_nxt.irqMask);
  end

  // =========================================================
  // registers
  always_ff @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      st_r                  <= '0;
      st_r.store            <= ST_IDLE;
      st_r.bank             <= 1'b0;
      st_r.loadPend         <= 1'b1;
      st_r.tempo            <= 32'(TEMPO_DEF_CYC);
      st_r.eng.tempoCycles  <= 32'(TEMPO_DEF_CYC);
      st_r.eng.preFadeListenFeedOn  <= 1'b1;
      st_r.eng.processorToAuxSendOn <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =========================================================
  // outputs
  assign s_axi_awready = st_r.awReady;
  assign s_axi_wready  = st_r.wReady;
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_arready = st_r.arReady;
  assign s_axi_rvalid  = st_r.rValid;
  assign s_axi_rdata   = st_r.rData;
  assign s_axi_rresp   = st_r.rResp;
  assign irq           = st_r.irqOut;
  assign leds          = st_r.leds;
  assign paramValue    = st_r.param;
  assign engine        = st_r.eng;

endmodule // epc_panel_ctrl

/* File: core/epc_pkg.sv */
// package: constants and types for the effects panel controller
package epc_pkg;

  // =========================================================
  // clock and timing
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned CYC_PER_MS     = CLK_MHZ * 1000;
  localparam int unsigned LOAD_MS        = 1000;
  localparam int unsigned STORE_HOLD_MS  = 3000;
  localparam int unsigned STORE_SHOW_MS  = 1000;
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned FAST_FLASH_MS  = 50;
  localparam int unsigned MUTE_BLINK_MS  = 250;
  localparam int unsigned TEMPO_DEF_MS   = 500;
  localparam int unsigned TEMPO_MAX_MS   = 5000;

  // =========================================================
  // program organisation
  localparam int unsigned NUM_BANKS      = 2;
  localparam int unsigned PROGS_PER_BANK = 16;
  localparam int unsigned NUM_PROGS      = NUM_BANKS * PROGS_PER_BANK;
  localparam int unsigned POS_W          = 4;
  localparam int unsigned PROG_W         = 5;
  localparam int unsigned KNOB_W         = 8;
  localparam int unsigned NUM_KNOBS      = 3;
  localparam int unsigned NUM_BUTTONS    = 4;
  localparam int unsigned BTN_TEMPO      = 0;
  localparam int unsigned BTN_STORE      = 1;
  localparam int unsigned BTN_MUTE       = 2;
  localparam int unsigned BTN_FOOT       = 3;
  localparam logic [POS_W-1:0] POS_LAST  = 4'h f;
  localparam logic [POS_W-1:0] POS_FIRST = 4'h0;

  // =========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_TEMPO    = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned IRQ_LOAD    = 0;
  localparam int unsigned IRQ_STORE   = 1;
  localparam int unsigned IRQ_CLIP    = 2;
  localparam int unsigned IRQ_TEMPO   = 3;
  localparam int unsigned CTRL_MUTE   = 0;
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;

  // =========================================================
  // types
  typedef enum {ST_IDLE, ST_HOLD, ST_WRITE, ST_SHOW} epc_store_t;

  typedef struct packed {
    logic [KNOB_W-1:0] k2;
    logic [KNOB_W-1:0] k1;
    logic [KNOB_W-1:0] k0;
  } epc_knobs_t;

  typedef struct packed {
    logic              loadStart;
    logic [PROG_W-1:0] loadProg;
    logic              storeWrite;
    logic [PROG_W-1:0] storeProg;
    logic              tempoSet;
    logic [31:0]       tempoCycles;
    logic              mainOutMute;
    logic              preFadeListenFeedOn;
    logic              processorToAuxSendOn;
  } epc_engine_t;

  typedef struct packed {
    logic bankALed;
    logic bankBLed;
    logic tempoLed;
    logic storeLed;
    logic clipLed;
    logic [NUM_KNOBS-1:0] knobLed;
  } epc_leds_t;

endpackage : epc_pkg

/* File: sim/epc_panel_model.sv */
// front-panel model: selector detents, buttons, knobs
`timescale 1ns/1ps
module epc_panel_model
  import epc_pkg::*;
(
  // clock
  input  wire logic             clk,
  // panel controls
  output logic                  selStep,
  output logic                  selDirDown,
  output logic [NUM_BUTTONS-1:0] buttonRaw,
  output epc_knobs_t            knobValue
);
  initial begin
    selStep = 1'b0;
    selDirDown = 1'b0;
    buttonRaw = '0;
    knobValue = '0;
  end
  // =====================================
  // one detent, spaced so no step shadows the last
  task automatic step(input logic dn);
    selStep <= 1'b1;
    selDirDown <= dn;
    @(posedge clk);
    selStep <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  // momentary closure then release; contacts settle before return
  task automatic press(input int b, input int len);
    buttonRaw[b] <= 1'b1;
    repeat (len) @(posedge clk);
    buttonRaw[b] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic turn(input epc_knobs_t v);
    knobValue <= v;
  endtask
endmodule // epc_panel_model

/* File: sim/epc_panel_asserts.sv */
// checker: port-level relations of the panel controller
`timescale 1ns/1ps
module epc_panel_asserts
  import epc_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // panel and engine
  input wire logic       selStep,
  input wire epc_knobs_t knobValue,
  input wire epc_knobs_t storedValue,
  input wire logic       inputClip,
  input wire logic       processedClip,
  input wire epc_leds_t  leds,
  input wire epc_knobs_t paramValue,
  input wire epc_engine_t engine
);
  logic [2:0] eq;
  always_comb eq = {knobValue.k2 == storedValue.k2, knobValue.k1 == storedValue.k1,
                    knobValue.k0 == storedValue.k0};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // =====================================
  // assertions
  a_feeds_live: assert property (engine.preFadeListenFeedOn && engine.processorToAuxSendOn)
    else $error("listen or aux feed off");
  a_step_load: assert property (selStep && !leds.storeLed ##1 !selStep && !leds.storeLed |=> engine.loadStart)
    else $error("no load after step");
  a_load_pulse: assert property (engine.loadStart |=> !engine.loadStart)
    else $error("load pulse too long");
  a_no_overlap: assert property (engine.storeWrite |-> !engine.loadStart)
    else $error("store and load together");
  a_store_show: assert property (engine.storeWrite |-> ##2 leds.storeLed [*8])
    else $error("store led not steady");
  a_bank_excl: assert property (!(leds.bankALed && leds.bankBLed))
    else $error("both bank leds lit");
  a_knob_match: assert property (1 |=> leds.knobLed == $past(eq))
    else $error("knob led mismatch");
  a_clip_on: assert property ((inputClip || processedClip) |=> leds.clipLed)
    else $error("clip led dark");
  a_param_copy: assert property (1 |=> paramValue == $past(knobValue))
    else $error("param copy wrong");
  c_store: cover property (engine.storeWrite);
  c_tempo: cover property (engine.tempoSet);
  c_mute: cover property ($rose(engine.mainOutMute));
endmodule // epc_panel_asserts
bind epc_panel_ctrl epc_panel_asserts u_chk (.clk, .rst_n, .selStep, .knobValue, .storedValue,
  .inputClip, .processedClip, .leds, .paramValue, .engine);

/* File: sim/effects_panel_controller_bench.sv */
// testbench: panel controller against a behavioural model
`timescale 1ns/1ps
module effects_panel_controller_bench;
  import epc_pkg::*;
  localparam int LD = 20, SH = 40, SS = 20, DB = 4, FH = 3, BH = 5, TD = 16, TM = 200;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, irq, selStep, selDirDown, inClip, prClip;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, tmp;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] wstrb;
  logic [NUM_BUTTONS-1:0] buttonRaw;
  epc_knobs_t knobValue, storedValue, paramValue, kv;
  epc_leds_t leds;
  epc_engine_t engine;
  int fail_count, checked, pos, bank, nLoad, nStore, nTempo, lastLoad, lastStore, n;
  epc_panel_model pm (.clk(clk), .selStep(selStep), .selDirDown(selDirDown), .buttonRaw(buttonRaw),
    .knobValue(knobValue));
  epc_panel_ctrl #(.LOAD_CYC(LD), .STORE_HOLD_CYC(SH), .STORE_SHOW_CYC(SS), .DEBOUNCE_CYC(DB),
    .FAST_HALF_CYC(FH), .BLINK_HALF_CYC(BH), .TEMPO_DEF_CYC(TD), .TEMPO_MAX_CYC(TM)) dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .selStep(selStep),
    .selDirDown(selDirDown), .buttonRaw(buttonRaw), .knobValue(knobValue), .leds(leds),
    .storedValue(storedValue), .inputClip(inClip), .processedClip(prClip),
    .paramValue(paramValue), .engine(engine));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (engine.loadStart) begin nLoad++; lastLoad = engine.loadProg; end
    if (engine.storeWrite) begin nStore++; lastStore = engine.storeProg; end
    if (engine.tempoSet) nTempo++;
  end
  // =====================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin fail_count++; $display("Error %s expected %h seen %h", nm, e, g); end
  endtask
  task automatic test_done;
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awrdy) awvalid <= 1'b0;
      if (wrdy) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp; bready <= 1'b0; @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin @(posedge clk); if (arrdy) arvalid <= 1'b0; end while (!rvalid);
    d = rdata; r = rresp; rready <= 1'b0; @(posedge clk);
  endtask
  // model position first, then step the selector one detent
  task automatic stepm(input logic dn);
    if (dn) begin if (pos == 0) bank ^= 1; pos = (pos + 15) % 16; end
    else begin pos = (pos + 1) % 16; if (pos == 0) bank ^= 1; end
    pm.step(dn);
    chk("loadProg", bank * 16 + pos, lastLoad);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
  // =====================================
  // main sequence
  initial begin
    rst_n = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = '0; araddr = '0; wdata = '0; storedValue = '1; inClip = 0; prClip = 0; wstrb = 4'hf;
    pos = 0; bank = 0;
    void'($urandom(86));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (LD + 10) @(posedge clk);
    chk("bootLoads", 1, nLoad);
    chk("bootProg", 0, lastLoad);
    chk("bankALed", 1, leds.bankALed);
    chk("feeds", 2'b11, {engine.preFadeListenFeedOn, engine.processorToAuxSendOn});
    axi_rd(REG_IRQ_STAT, rd, rs);
    chk("bootDone", 1, rd[IRQ_LOAD]);
    axi_wr(REG_IRQ_MASK, 32'h0000_0001, rs);
    chk("maskResp", RESP_OKAY, rs);
    for (int i = 0; i < 17; i++) stepm(1'b0);
    chk("bankBLed", 1, leds.bankBLed);
    stepm(1'b1);
    stepm(1'b1);
    chk("bankBack", 1, leds.bankALed);
    repeat (LD + 5) @(posedge clk);
    chk("irqLoad", 1, irq);
    axi_rd(REG_IRQ_STAT, rd, rs);
    chk("statLoad", 1, rd[IRQ_LOAD]);
    repeat (3) @(posedge clk);
    chk("irqClear", 0, irq);
    axi_rd(REG_STATUS, rd, rs);
    chk("statusProg", bank * 16 + pos, rd[4:0]);
    axi_rd(8'h40, rd, rs);
    chk("rdUnmapped", RESP_SLVERR, rs);
    axi_wr(8'h44, 32'h0000_0001, rs);
    chk("wrUnmapped", RESP_SLVERR, rs);
    wstrb <= 4'he;
    axi_wr(REG_IRQ_MASK, 32'h0000_0000, rs);
    wstrb <= 4'hf;
    axi_rd(REG_IRQ_MASK, rd, rs);
    chk("maskBack", 1, rd);
    axi_wr(REG_CTRL, 32'h0000_0001, rs);
    chk("muteSw", 1, engine.mainOutMute);
    axi_wr(REG_CTRL, 32'h0000_0000, rs);
    // footswitch mutes; bank led must blink both ways
    pm.press(BTN_FOOT, 10);
    chk("muteFoot", 1, engine.mainOutMute);
    chk("feedsMuted", 2'b11, {engine.preFadeListenFeedOn, engine.processorToAuxSendOn});
    n = 0;
    repeat (12) begin @(posedge clk); n += leds.bankALed; end
    chk("blink", 1, n > 0 && n < 12);
    pm.press(BTN_MUTE, 10);
    chk("unmute", 0, engine.mainOutMute);
    // two taps sixty cycles apart
    pm.press(BTN_TEMPO, 10);
    repeat (42) @(posedge clk);
    pm.press(BTN_TEMPO, 10);
    chk("tempoSets", 1, nTempo);
    chk("tempoNear", 1, engine.tempoCycles >= 58 && engine.tempoCycles <= 62);
    n = 0;
    repeat (60) begin @(posedge clk); n += leds.tempoLed; end
    chk("tempoFlash", 1, n >= 26 && n <= 34);
    pm.press(BTN_STORE, 20);
    chk("shortStore", 0, nStore);
    fork
      pm.press(BTN_STORE, 60);
      begin
        repeat (20) @(posedge clk);
        n = 0;
        repeat (12) begin @(posedge clk); n += leds.storeLed; end
        chk("storeFlash", 1, n > 0 && n < 12);
        repeat (16) @(posedge clk);
        n = nLoad;
        pm.step(1'b1);
        chk("loadHeld", n, nLoad);
      end
    join
    chk("longStore", 1, nStore);
    chk("storeProg", bank * 16 + pos, lastStore);
    chk("storeIdle", 0, leds.storeLed);
    pos = (pos + 15) % 16;
    @(posedge clk);
    chk("loadAfter", bank * 16 + pos, lastLoad);
    tmp = $urandom;
    kv = tmp[23:0];
    storedValue <= {kv.k2 ^ 8'h01, kv.k1, kv.k0};
    pm.turn(kv);
    repeat (3) @(posedge clk);
    chk("knobLed", 3'b011, leds.knobLed);
    chk("paramValue", kv, paramValue);
    prClip <= 1'b1;
    repeat (3) @(posedge clk);
    chk("clipProc", 1, leds.clipLed);
    prClip <= 1'b0;
    inClip <= 1'b1;
    repeat (3) @(posedge clk);
    chk("clipIn", 1, leds.clipLed);
    inClip <= 1'b0;
    repeat (3) @(posedge clk);
    chk("clipOff", 0, leds.clipLed);
    test_done();
  end
endmodule // effects_panel_controller_bench
